// *** acq_core.sv ***
// acquisition controller: pacing, trigger, group delay handling, scan assembly, buffer writes
// assumes converters and digital sources run on clk; trigger pins arrive asynchronously
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`include "acq_regs.svh"

module acq_core
  import acq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // avalon-mm slave
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // converters
  input wire adc_bundle_s adc_in,
  input wire logic adc_valid,
  output logic conv_sync,
  // digital sources, sampled at each tick
  input wire dig_bundle_s dig_in,
  // trigger sources
  input wire logic ext_trig,
  input wire logic [5:0] lxi_trig,
  input wire logic lan_trig,
  // front end controls
  output logic gain_ten,
  output logic [3:0] iepe_en,
  output logic [3:0] ac_coupling,
  // indicators
  output logic led_amber,
  output logic led_green,
  // buffer write port
  output mem_wr_s mem_wr
);

  // register state
  logic [31:0] ctrl_q;
  logic [7:0] chen_q;
  logic [19:0] freq_q;
  logic [23:0] thresh_q;
  logic [13:0] xfer_q;
  logic [31:0] rdata_q;
  logic wait_q;
  state_e state_q;
  logic [20:0] wptr_q;
  logic [21:0] count_q;
  logic full_q;

  logic acc_wr, acc_rd;
  logic cmd_arm, cmd_start, cmd_stop;
  trig_src_e src;
  logic wrap_mode;

  assign acc_wr = write && !wait_q;
  assign acc_rd = read && !wait_q;
  assign cmd_arm = acc_wr && address == `REG_CMD && writedata[`CMD_ARM];
  assign cmd_start = acc_wr && address == `REG_CMD && writedata[`CMD_START];
  assign cmd_stop = acc_wr && address == `REG_CMD && writedata[`CMD_STOP];
  assign src = trig_src_e'(ctrl_q[`CTRL_SRC_LO +: 3]);
  assign wrap_mode = ctrl_q[`CTRL_WRAP];

  // one wait cycle, then a single low cycle carrying the answer
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(wait_q && (read || write));
    end
  end

  // writable registers; unmapped writes are dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= {13'h0000, `AC_RST, 15'h0000};
      chen_q <= `CHEN_RST;
      freq_q <= `FREQ_RST;
      thresh_q <= `THR_MIN;
      xfer_q <= `XFER_MAX;
    end else if (acc_wr) begin
      case (address)
        `REG_CTRL: ctrl_q <= {13'h0000, writedata[18:0]};
        `REG_CHEN: chen_q <= writedata[7:0];
        `REG_FREQ: begin
          // request outside the range is clamped, so the oscillator stays under its ceiling
          if (writedata < {12'h000, `FREQ_MIN}) begin
            freq_q <= `FREQ_MIN;
          end else if (writedata > {12'h000, `FREQ_MAX}) begin
            freq_q <= `FREQ_MAX;
          end else begin
            freq_q <= writedata[19:0];
          end
        end
        `REG_THRESH: begin
          if (writedata[23:0] < `THR_MIN) begin
            thresh_q <= `THR_MIN;
          end else if (writedata[23:0] > `THR_MAX) begin
            thresh_q <= `THR_MAX;
          end else begin
            thresh_q <= writedata[23:0];
          end
        end
        `REG_XFER: begin
          // one network read is capped at 8k samples
          if (writedata > {18'h00000, `XFER_MAX}) begin
            xfer_q <= `XFER_MAX;
          end else begin
            xfer_q <= writedata[13:0];
          end
        end
        default: ;
      endcase
    end
  end

  // front end controls straight from the control register
  always_ff @(posedge clk) begin
    if (srst) begin
      gain_ten <= 1'b0;
      iepe_en <= 4'h0;
      ac_coupling <= `AC_RST;
    end else begin
      gain_ten <= ctrl_q[`CTRL_GAIN];
      iepe_en <= ctrl_q[`CTRL_IEPE_LO +: 4];
      ac_coupling <= ctrl_q[`CTRL_AC_LO +: 4];
    end
  end

  // sample clock: phase accumulator stepping at freq * 2^32 / (clk * 10)
  logic [40:0] step_prod;
  logic [23:0] step_q;
  logic [31:0] phase_q;
  logic [32:0] phase_sum;
  logic [39:0] act_prod;
  logic [31:0] osc_dhz;
  logic tick;
  assign step_prod = {21'h000000, freq_q} * {20'h00000, `STEP_K};
  assign act_prod = {16'h0000, step_q} * {24'h000000, `ACT_K};
  assign osc_dhz = {12'h000, freq_q} * {22'h000000, `OSC_MULT};
  assign phase_sum = {1'b0, phase_q} + {9'h000, step_q};
  assign tick = phase_sum[32] && state_q != ST_IDLE;

  always_ff @(posedge clk) begin
    if (srst) begin
      step_q <= 24'h000000;
      phase_q <= 32'h00000000;
    end else begin
      step_q <= step_prod[39:16];
      // clock runs only while armed or acquiring
      phase_q <= (state_q == ST_IDLE) ? 32'h00000000 : phase_sum[31:0];
    end
  end

  // shared sync pulse clocks every converter on the same edge
  always_ff @(posedge clk) begin
    if (srst) begin
      conv_sync <= 1'b0;
    end else begin
      conv_sync <= tick;
    end
  end

  // pin synchronisers; edge detect looks only at the second stage onward
  logic [6:0] pin_s1_q, pin_s2_q, pin_s3_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
      pin_s3_q <= 7'h00;
    end else begin
      pin_s1_q <= {lxi_trig, ext_trig};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic ext_rise, bus_rise;
  logic [2:0] lxi_sel;
  assign lxi_sel = ctrl_q[`CTRL_LXI_LO +: 3];
  assign ext_rise = pin_s2_q[0] && !pin_s3_q[0];
  assign bus_rise = (lxi_sel < 3'h6) && pin_s2_q[3'h1 + lxi_sel] && !pin_s3_q[3'h1 + lxi_sel];

  // threshold on input 1 with hysteresis: re-arms only below level minus 0.1 V
  logic thr_below_q, thr_cross;
  logic signed [23:0] ch1;
  assign ch1 = adc_in.data[0];
  assign thr_cross = adc_valid && thr_below_q && ch1 > $signed(thresh_q);
  always_ff @(posedge clk) begin
    if (srst) begin
      thr_below_q <= 1'b0;
    end else if (adc_valid) begin
      if (ch1 < $signed(thresh_q - `HYST_CODE)) begin
        thr_below_q <= 1'b1;
      end else if (ch1 > $signed(thresh_q)) begin
        thr_below_q <= 1'b0;
      end
    end
  end

  // trigger select
  logic trig_evt;
  always_comb begin
    case (src)
      SRC_IMMEDIATE: trig_evt = cmd_start;
      SRC_EXTERNAL: trig_evt = ext_rise;
      SRC_THRESHOLD: trig_evt = thr_cross;
      SRC_BUS: trig_evt = bus_rise;
      SRC_NETWORK: trig_evt = lan_trig;
      default: trig_evt = 1'b0;
    endcase
  end

  // scan sizing and buffer fit
  logic [3:0] nscan;
  logic fits;
  always_comb begin
    nscan = 4'h0;
    for (int i = 0; i < 8; i++) begin
      nscan = nscan + {3'h0, chen_q[i]};
    end
  end
  assign fits = ({1'b0, wptr_q} + {18'h00000, nscan}) <= `BUF_WORDS;

  // group delay counter and scan sequencer
  logic [5:0] gd_cnt_q;
  logic [3:0] seq_q;
  logic stop_full;
  assign stop_full = tick && state_q == ST_RUN && !wrap_mode && !fits;

  // acquisition sequence
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else if (cmd_stop) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (cmd_arm) state_q <= ST_ARMED;
        ST_ARMED: if (trig_evt) state_q <= ST_DELAY;
        ST_DELAY: if (tick && gd_cnt_q == `GROUP_DELAY - 6'h01) state_q <= ST_RUN;
        ST_RUN: if (stop_full) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // counts the 39 ticks whose converter outputs are not yet the trigger-time sample
  always_ff @(posedge clk) begin
    if (srst || state_q != ST_DELAY) begin
      gd_cnt_q <= 6'h00;
    end else if (tick) begin
      gd_cnt_q <= gd_cnt_q + 6'h01;
    end
  end

  // digital sources lack converter latency: 39-deep ring realigns them
  dig_bundle_s dq_mem [0:38];
  logic [5:0] dq_idx_q;
  dig_bundle_s dq_out_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      dq_idx_q <= 6'h00;
      dq_out_q <= '0;
    end else if (tick) begin
      dq_out_q <= dq_mem[dq_idx_q];
      dq_idx_q <= (dq_idx_q == `GROUP_DELAY - 6'h01) ? 6'h00 : dq_idx_q + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (tick) begin
      dq_mem[dq_idx_q] <= dig_in;
    end
  end

  // latch the converter result that pairs with this tick's delayed digital data
  adc_bundle_s adc_hold_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      adc_hold_q <= '0;
    end else if (adc_valid) begin
      adc_hold_q <= adc_in;
    end
  end

  // scan walker: eight slots, one per cycle, enabled ones written in channel order
  logic [31:0] slot_word;
  always_comb begin
    if (seq_q[2:0] < 3'h4) begin
      slot_word = {{8{adc_hold_q.data[seq_q[1:0]][23]}}, adc_hold_q.data[seq_q[1:0]]};
    end else begin
      slot_word = dq_out_q.data[seq_q[1:0]];
    end
  end

  // run tick delayed one cycle, so slot 0 reads this tick's conversion and not the one before
  logic run_tick_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      run_tick_q <= 1'b0;
    end else begin
      run_tick_q <= state_q == ST_RUN && tick && (fits || wrap_mode);
    end
  end

  // scan starts after a tick in run state; outputs during the delay are thrown away
  always_ff @(posedge clk) begin
    if (srst || state_q == ST_IDLE) begin
      seq_q <= 4'h0;
    end else if (run_tick_q && seq_q == 4'h0) begin
      seq_q <= 4'h8;
    end else if (seq_q != 4'h0) begin
      seq_q <= (seq_q[2:0] == 3'h7) ? 4'h0 : {1'b1, seq_q[2:0] + 3'h1};
    end
  end

  // buffer writes and pointer
  logic slot_we;
  assign slot_we = seq_q[3] && chen_q[seq_q[2:0]];
  always_ff @(posedge clk) begin
    if (srst) begin
      mem_wr <= '0;
      wptr_q <= 21'h000000;
      count_q <= 22'h000000;
      full_q <= 1'b0;
    end else begin
      mem_wr.we <= slot_we;
      mem_wr.wdata <= slot_word;
      if (cmd_arm && state_q == ST_IDLE) begin
        wptr_q <= 21'h000000;
        count_q <= 22'h000000;
        full_q <= 1'b0;
      end else begin
        if (slot_we) begin
          mem_wr.addr <= wptr_q;
          // 21-bit pointer rolls from the last word back to zero
          wptr_q <= wptr_q + 21'h000001;
          if (count_q != `BUF_WORDS) begin
            count_q <= count_q + 22'h000001;
          end
        end
        if (stop_full) begin
          full_q <= 1'b1;
        end
      end
    end
  end

  // wrap mode: pointer runs past the end back to zero, overwriting oldest
  // handled by the pointer roll above; a scan may straddle the end

  // indicators
  always_ff @(posedge clk) begin
    if (srst) begin
      led_amber <= 1'b0;
      led_green <= 1'b0;
    end else begin
      led_amber <= state_q == ST_ARMED;
      led_green <= state_q == ST_DELAY || state_q == ST_RUN;
    end
  end

  // read mux, captured in the wait cycle; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h00000000;
    end else if (wait_q && read) begin
      case (address)
        `REG_CTRL: rdata_q <= ctrl_q;
        `REG_CHEN: rdata_q <= {24'h000000, chen_q};
        `REG_FREQ: rdata_q <= {12'h000, freq_q};
        `REG_FREQ_ACT: rdata_q <= act_prod[39:20] > 20'h0 ? {12'h000, act_prod[39:20]} : 32'h0;
        `REG_OSC: rdata_q <= osc_dhz;
        `REG_THRESH: rdata_q <= {8'h00, thresh_q};
        `REG_STATUS: rdata_q <= {19'h00000, `RES_BITS, 2'h0, full_q, led_green, led_amber, state_q};
        `REG_WPTR: rdata_q <= {11'h000, wptr_q};
        `REG_COUNT: rdata_q <= {10'h000, count_q};
        `REG_XFER: rdata_q <= {18'h00000, xfer_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;

endmodule // acq_core

// *** acq_regs.svh ***
// register offsets, field positions, reset values and timing counts of the acquisition block
// assumes a 20 MHz clk and Avalon-MM byte addresses, one aligned 32-bit word per register
//
// How it works
// - enabled inputs 1-4 sampled together each tick
// - scan holds one sample per enabled source
// - buffer holds 2M four-byte samples
// - wrap mode restarts pointer, overwrites oldest
// - no-wrap mode stops itself when full; with 1, 2, 4 or 8 sources enabled the pointer rolls to zero instead
// - sample rate clamped 195.3 Hz-52.734 kHz, reported
// - oscillator is 512 times rate, max 27 MHz
// - first 39 sample pulses are group delay
// - discard delayed outputs; first stored equals trigger
// - digital sources delayed to match analog scans
// - arm first; immediate source also needs start
// - continuous mode runs until software stop
// - amber when armed, green triggered, off idle
// - start write is the immediate trigger event
// - external source triggers on rising edge
// - channel 1 threshold trigger with hysteresis
// - bus source uses selected line of six
// - network source starts on trigger packet
// - input gain 1 or 10
// - per-input excitation enable and coupling select
// - one buffered read returns at most 8k samples
`ifndef ACQ_REGS_SVH
`define ACQ_REGS_SVH

// register byte offsets
`define REG_CTRL 6'h00
`define REG_CMD 6'h04
`define REG_CHEN 6'h08
`define REG_FREQ 6'h0c
`define REG_FREQ_ACT 6'h10
`define REG_OSC 6'h14
`define REG_THRESH 6'h18
`define REG_STATUS 6'h1c
`define REG_WPTR 6'h20
`define REG_COUNT 6'h24
`define REG_XFER 6'h28

// control field positions
`define CTRL_WRAP 3
`define CTRL_SRC_LO 4
`define CTRL_LXI_LO 7
`define CTRL_GAIN 10
`define CTRL_IEPE_LO 11
`define CTRL_AC_LO 15
`define CMD_ARM 0
`define CMD_START 1
`define CMD_STOP 2

// reset values
`define CHEN_RST 8'h0f
`define AC_RST 4'hf
`define FREQ_RST 20'h02710

// sample rate in 0.1 Hz units; 1953 = 195.3 Hz, 527340 = 52.734 kHz
`define FREQ_MIN 20'h007a1
`define FREQ_MAX 20'h80bec
`define OSC_MULT 10'h200
`define OSC_MAX_DHZ 32'h1017df80
// phase step = freq * 2^48 / (clk * 10) >> 16 ; achieved = step * (clk*10*2^20/2^32) >> 20
`define CLK_HZ 32'h01312d00
`define STEP_K 21'h1579ef
`define ACT_K 16'hbebc

// timing and sizes
`define GROUP_DELAY 6'h27
`define BUF_WORDS 22'h200000
`define XFER_MAX 14'h2000
`define RES_BITS 5'h18
// 0.1 V of hysteresis at 10 V full scale on a 24-bit code
`define HYST_CODE 24'h0147ae
`define THR_MIN 24'h028f5c
`define THR_MAX 24'h7d70a3

`endif

// *** acq_pkg.sv ***
// types shared by the acquisition block
// assumes acq_regs.svh supplies all numeric constants
package acq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_DELAY,
    ST_RUN
  } state_e;

  typedef enum logic [2:0] {
    SRC_IMMEDIATE,
    SRC_EXTERNAL,
    SRC_THRESHOLD,
    SRC_BUS,
    SRC_NETWORK
  } trig_src_e;

  // one simultaneous conversion of the four inputs
  typedef struct packed {
    logic [3:0][23:0] data;
  } adc_bundle_s;

  // tachometer, two counters, output readback
  typedef struct packed {
    logic [3:0][31:0] data;
  } dig_bundle_s;

  // buffer write port
  typedef struct packed {
    logic we;
    logic [20:0] addr;
    logic [31:0] wdata;
  } mem_wr_s;
endpackage

// *** conv_model.sv ***
// converter and digital source model at the far side of the block
// assumes conv_sync is a one-cycle pulse on clk and answers it in the same cycle
module conv_model
  import acq_pkg::*;
(
  // clock
  input wire logic clk,
  // converters
  input wire logic conv_sync,
  output adc_bundle_s adc_in,
  output logic adc_valid,
  // digital sources
  output dig_bundle_s dig_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] n_q = 5'h0;

  // tick count; wraps at 32 so the channel 1 ramp keeps crossing a threshold
  always_ff @(posedge clk) begin
    if (conv_sync) n_q <= n_q + 5'h1;
  end

  // one conversion for all four inputs per pulse, result from 39 ticks back (7 mod 32)
  assign adc_valid = conv_sync;
  always_comb begin
    logic [23:0] v;
    v = 24'h000000;
    for (int i = 0; i < 4; i++) begin
      v = {(i == 3) ? 3'h7 : 3'h0, n_q - 5'd7, 16'(i + 1)};
      adc_in.data[i] = conv_sync ? v : ~v; // data lines not held outside the pulse
      dig_in.data[i] = {8'(i + 5), 19'h0, n_q};
    end
  end
endmodule // conv_model

// *** acq_sva.sv ***
// port assertions of the acquisition block
// assumes one clk domain with synchronous active-high srst
`include "acq_regs.svh"
module acq_sva
  import acq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register bus
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  // pacing and storage
  input wire logic conv_sync,
  input wire mem_wr_s mem_wr,
  // indicators
  input wire logic led_amber,
  input wire logic led_green
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic acc_w, wrap_q, stop_q, seen_q;
  logic [20:0] last_q;
  logic [5:0] tick_q;
  assign acc_w = write && !waitrequest;

  // shadow of wrap mode and of stop commands; arming forgets an old stop
  always_ff @(posedge clk) begin
    if (srst) begin
      wrap_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (acc_w && address == `REG_CTRL) wrap_q <= writedata[`CTRL_WRAP];
      if (acc_w && address == `REG_CMD && writedata[`CMD_STOP]) stop_q <= 1'b1;
      else if (led_amber) stop_q <= 1'b0;
    end
  end

  // ticks since trigger (saturating) and last stored address
  always_ff @(posedge clk) begin
    if (srst || !led_green) begin
      tick_q <= 6'h0;
      seen_q <= 1'b0;
    end else begin
      if (conv_sync && tick_q != 6'h3f) tick_q <= tick_q + 6'h1;
      if (mem_wr.we) seen_q <= 1'b1;
      if (mem_wr.we) last_q <= mem_wr.addr;
    end
  end

  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_ans;
    !waitrequest ##1 waitrequest;
  endsequence
  property p_bus_ans;
    s_req |=> s_ans;
  endproperty
  a_bus_ans: assert property (p_bus_ans) else $error("bus answer not one wait cycle");
  property p_bus_idle;
    !waitrequest |-> read || write;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("answer without request");
  property p_led_excl;
    !(led_amber && led_green);
  endproperty
  a_led_excl: assert property (p_led_excl) else $error("both indicators lit");
  property p_no_store_armed;
    mem_wr.we |-> !led_amber;
  endproperty
  a_no_store_armed: assert property (p_no_store_armed) else $error("store before trigger");
  property p_sync_pulse;
    conv_sync |=> !conv_sync;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse) else $error("sample pulse too long");
  property p_addr_seq;
    mem_wr.we && seen_q |-> mem_wr.addr == last_q + 21'h1;
  endproperty
  a_addr_seq: assert property (p_addr_seq) else $error("store address not sequential");
  property p_group_delay;
    mem_wr.we |-> tick_q >= 6'd40;
  endproperty
  a_group_delay: assert property (p_group_delay) else $error("store inside group delay");
  property p_cont_stop;
    $fell(led_green) && !$past(srst) |-> stop_q || !wrap_q;
  endproperty
  a_cont_stop: assert property (p_cont_stop) else $error("wrap run ended by itself");
endmodule // acq_sva

bind acq_core acq_sva u_sva (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
  .writedata(writedata), .waitrequest(waitrequest), .conv_sync(conv_sync), .mem_wr(mem_wr),
  .led_amber(led_amber), .led_green(led_green));

// *** testbench.sv ***
// testbench: register walk, one full acquisition, then every trigger source
// assumes conv_model answers each sample pulse at once
`include "acq_regs.svh"
module testbench
  import acq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, srst = 1, read = 0, write = 0, ext_trig = 0, lan_trig = 0;
  logic [5:0] address = 0, lxi_trig = 0;
  logic [31:0] writedata = 0, q, readdata;
  logic waitrequest, conv_sync, adc_valid, gain_ten, led_amber, led_green;
  logic [3:0] iepe_en, ac_coupling;
  logic [4:0] m, mw;
  adc_bundle_s adc_in;
  dig_bundle_s dig_in;
  mem_wr_s mem_wr;
  int n_fail = 0, compares = 0, cyc = 0, p = 0, nw = 0;
  int src[4] = '{1, 3, 4, 2};
  int bad[4] = '{2, 5, 1, 8};
  int good[4] = '{1, 8, 2, 0};
  bit got = 0;
  localparam logic [7:0] CHEN_RUN = 8'h9b;

  acq_core dut (.clk(clk), .srst(srst), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .adc_in(adc_in), .adc_valid(adc_valid), .conv_sync(conv_sync),
    .dig_in(dig_in), .ext_trig(ext_trig), .lxi_trig(lxi_trig), .lan_trig(lan_trig), .gain_ten(gain_ten),
    .iepe_en(iepe_en), .ac_coupling(ac_coupling), .led_amber(led_amber), .led_green(led_green), .mem_wr(mem_wr));
  conv_model u_conv (.clk(clk), .conv_sync(conv_sync), .adc_in(adc_in), .adc_valid(adc_valid), .dig_in(dig_in));

  always #25 clk = ~clk;

  // hang guard, well above the roughly 29k cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one avalon access; request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    check(q, e);
  endtask

  task automatic wait_st(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim; i++) begin
      acc(1'b0, `REG_STATUS, 32'h0);
      if (q[2:0] === s) break;
    end
  endtask

  // trigger event: 1 ext, 2 lan, 3+j bus line j, 0 none; lan is a one-cycle pulse
  task automatic ev(input int k);
    ext_trig <= (k == 1);
    lan_trig <= (k == 2);
    lxi_trig <= (k > 2) ? 6'(1 << (k - 3)) : 6'h0;
    repeat ((k == 2) ? 1 : 3) @(posedge clk);
    ext_trig <= 1'b0;
    lan_trig <= 1'b0;
    lxi_trig <= 6'h0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] exp_w(input int c, input logic [4:0] k);
    logic [23:0] v;
    v = {(c == 3) ? 3'h7 : 3'h0, k, 16'(c + 1)};
    return (c < 4) ? {{8{v[23]}}, v} : {8'(c + 1), 19'h0, k};
  endfunction

  // scan monitor: enabled channels in order, one tick apart
  always @(posedge clk) begin
    if (mem_wr.we === 1'b1) begin
      while (!CHEN_RUN[p]) p = (p + 1) % 8;
      mw = (p < 4) ? mem_wr.wdata[20:16] : mem_wr.wdata[4:0];
      if (p == 0) begin
        if (got) check(32'(mw), 32'(m + 5'h1));
        got = 1;
        m = mw;
      end
      check(mem_wr.wdata, exp_w(p, m));
      check(32'(mem_wr.addr), 32'(nw));
      p = (p + 1) % 8;
      nw++;
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(32'({iepe_en, ac_coupling}), 32'hf);
    rc(`REG_CTRL, 32'h78000);
    rc(`REG_CHEN, 32'hf);
    rc(`REG_FREQ, 32'h2710);
    rc(`REG_STATUS, 32'h1800);
    rc(6'h2c, 32'h0);
    acc(1'b1, `REG_STATUS, 32'h0);
    rc(`REG_STATUS, 32'h1800);
    acc(1'b1, `REG_FREQ, 32'h1);
    rc(`REG_FREQ, 32'h7a1);
    acc(1'b1, `REG_FREQ, 32'hfffff);
    rc(`REG_FREQ, 32'h80bec);
    rc(`REG_OSC, 32'h1017d800);
    // achieved rate within a tenth of a percent of the request
    acc(1'b0, `REG_FREQ_ACT, 32'h0);
    check(32'(q > 32'd526812 && q < 32'd527868), 32'h1);
    acc(1'b1, `REG_XFER, 32'hffff);
    rc(`REG_XFER, 32'h2000);
    acc(1'b1, `REG_THRESH, 32'h0);
    rc(`REG_THRESH, 32'h28f5c);
    acc(1'b1, `REG_THRESH, 32'h30000);
    acc(1'b1, `REG_CTRL, 32'h2d400);
    @(posedge clk);
    check(32'({gain_ten, iepe_en, ac_coupling}), 32'h1a5);
    acc(1'b1, `REG_CMD, 32'h2);
    rc(`REG_STATUS, 32'h1800);
    acc(1'b1, `REG_CHEN, 32'(CHEN_RUN));
    acc(1'b1, `REG_CTRL, 32'h8);
    acc(1'b1, `REG_CMD, 32'h1);
    rc(`REG_STATUS, 32'h1809);
    repeat (1500) @(posedge clk);
    rc(`REG_STATUS, 32'h1809);
    acc(1'b1, `REG_CMD, 32'h2);
    wait_st(3'h2, 20);
    check(q, 32'h1812);
    wait_st(3'h3, 8000);
    check(q, 32'h1813);
    repeat (2500) @(posedge clk);
    acc(1'b1, `REG_CMD, 32'h4);
    rc(`REG_STATUS, 32'h1800);
    check(32'(nw > 8), 32'h1);
    rc(`REG_COUNT, 32'(nw));
    rc(`REG_WPTR, 32'(nw));
    // each source ignores a foreign event, then fires on its own
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, `REG_CTRL, (32'(src[i]) << 4) | 32'h280);
      acc(1'b1, `REG_CMD, 32'h1);
      ev(bad[i]);
      rc(`REG_STATUS, 32'h1809);
      ev(good[i]);
      wait_st(3'h2, 5000);
      check(q, 32'h1812);
      acc(1'b1, `REG_CMD, 32'h4);
    end
    summarize();
  end
endmodule // testbench
